// >>> csf_regs.svh
// Behaviour
// - The arithmetic flags, the reset-cause flags and the bank select bits live together in one status register.
// - The status register may be the destination of any instruction, like any other file register.
// - If an instruction that updates zero, digit carry or carry also writes the status register, those bits come from the flag logic, not the written value.
// - Writes to the watchdog time-out and power-down flags are ignored; they keep their hardware values.
// - Clearing the status register clears the three upper bank bits and sets zero, leaving the other bits unchanged.
// - Bit clear, bit set, nibble swap and move-to-file change zero, digit carry or carry only when the status register is their destination.
// - In subtraction, carry is an active-low borrow and digit carry an active-low digit borrow.
// - The watchdog time-out flag sits at bit 4, reads one after power-up, watchdog clear or sleep, and zero after a time-out.
// - The power-down flag sits at bit 3, is set by power-up or watchdog clear, and cleared by sleep.
// - Carry sits at bit 0 and is set by a carry-out of the most significant bit in add and subtract.
// - Subtraction adds the two's complement of the second operand; rotates load carry from the high or low source bit.
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

`define CSF_OFS_STATUS 8'h00
`define CSF_OFS_RESULT 8'h04

`define CSF_BIT_C 0
`define CSF_BIT_DC 1
`define CSF_BIT_Z 2
`define CSF_BIT_PD 3
`define CSF_BIT_TO 4
`define CSF_BIT_RP_LO 5
`define CSF_BIT_RP_HI 6
`define CSF_BIT_IRP 7

`define CSF_STATUS_RST 8'h18

`endif

// >>> csf_pkg.sv
package csf_pkg;

  typedef enum logic [3:0] {
    CSF_OP_NONE = 4'h0,
    CSF_OP_ADD = 4'h1,
    CSF_OP_SUB = 4'h2,
    CSF_OP_AND = 4'h3,
    CSF_OP_IOR = 4'h4,
    CSF_OP_XOR = 4'h5,
    CSF_OP_MOVE = 4'h6,
    CSF_OP_CLR = 4'h7,
    CSF_OP_RLF = 4'h8,
    CSF_OP_RRF = 4'h9
  } csf_op_t;

  // One instruction step from the core; opa is f (or the ready result for MOVE), opb is w
  typedef struct packed {
    logic valid;
    csf_op_t op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic dest_status;
    logic sleep;
    logic wdt_clear;
    logic wdt_timeout;
  } csf_core_req_t;

  // Flag vectors are ordered {z, dc, c}
  typedef struct packed {
    logic [7:0] res;
    logic [2:0] upd;
    logic [2:0] flags;
  } csf_alu_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] result;
    logic result_valid;
    logic ack;
    logic [31:0] rdata;
  } csf_state_t;

endpackage : csf_pkg

// >>> csf_status_reg.sv
`timescale 1ns/1ns
`include "csf_regs.svh"

module csf_status_reg (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core execution side
  input wire csf_pkg::csf_core_req_t core_req,
  output logic [7:0] status_o,
  output logic [7:0] result_o,
  output logic result_valid_o
);
  import csf_pkg::*;

  csf_state_t st_ff;
  csf_state_t nxt_st;
  csf_alu_t alu;
  logic bus_req;
  logic [7:0] wstat;

  // Eight-bit add with carry in; result is {digit carry, carry, sum}
  function automatic logic [9:0] csf_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'h0, a} + {1'h0, b} + {8'h00, cin};
    h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
    return {h[4], s};
  endfunction

  // Flag logic of one instruction
  function automatic csf_alu_t csf_alu(input csf_op_t op, input logic [7:0] a, input logic [7:0] b,
                                       input logic c_in);
    logic [9:0] sum;
    csf_alu_t o;
    o = '0;
    sum = 10'h000;
    case (op)
      CSF_OP_ADD: begin
        sum = csf_add(a, b, 1'h0);
        o.res = sum[7:0];
        o.upd = 3'h7;
        o.flags[1:0] = sum[9:8];
      end
      CSF_OP_SUB: begin
        // Two's complement add: a carry out means no borrow, so both flags are active-low borrows
        sum = csf_add(a, ~b, 1'h1);
        o.res = sum[7:0];
        o.upd = 3'h7;
        o.flags[1:0] = sum[9:8];
      end
      CSF_OP_AND: begin
        o.res = a & b;
        o.upd = 3'h4;
      end
      CSF_OP_IOR: begin
        o.res = a | b;
        o.upd = 3'h4;
      end
      CSF_OP_XOR: begin
        o.res = a ^ b;
        o.upd = 3'h4;
      end
      CSF_OP_CLR: begin
        o.res = 8'h00;
        o.upd = 3'h4;
      end
      CSF_OP_RLF: begin
        o.res = {a[6:0], c_in};
        o.upd = 3'h1;
        o.flags[0] = a[7];
      end
      CSF_OP_RRF: begin
        o.res = {c_in, a[7:1]};
        o.upd = 3'h1;
        o.flags[0] = a[0];
      end
      CSF_OP_MOVE: begin
        // Bit set/clear, swap and move arrive here with the result already formed
        o.res = a;
        o.upd = 3'h0;
      end
      default: begin
        o.res = a;
        o.upd = 3'h0;
      end
    endcase
    o.flags[2] = (o.res == 8'h00);
    return o;
  endfunction

  // Hardware flag update on top of a given status value
  function automatic logic [7:0] csf_apply(input logic [7:0] base, input logic [2:0] upd,
                                           input logic [2:0] flags);
    logic [7:0] n;
    n = base;
    if (upd[2]) begin
      n[`CSF_BIT_Z] = flags[2];
    end
    if (upd[1]) begin
      n[`CSF_BIT_DC] = flags[1];
    end
    if (upd[0]) begin
      n[`CSF_BIT_C] = flags[0];
    end
    return n;
  endfunction

  // Merge of a written value with flag updates; shared by core and bus writes
  function automatic logic [7:0] csf_merge(input logic [7:0] old, input logic [7:0] wval,
                                           input logic [2:0] upd, input logic [2:0] flags);
    logic [7:0] n;
    // Time-out and power-down are never taken from the written value
    n = old;
    n[`CSF_BIT_IRP] = wval[`CSF_BIT_IRP];
    n[`CSF_BIT_RP_HI:`CSF_BIT_RP_LO] = wval[`CSF_BIT_RP_HI:`CSF_BIT_RP_LO];
    if (upd == 3'h0) begin
      n[`CSF_BIT_Z] = wval[`CSF_BIT_Z];
      n[`CSF_BIT_DC] = wval[`CSF_BIT_DC];
      n[`CSF_BIT_C] = wval[`CSF_BIT_C];
    end else begin
      // Touching any arithmetic flag blocks the write to all three; untouched ones keep their value
      n = csf_apply(n, upd, flags);
    end
    return n;
  endfunction

  // Reset-cause flags {to, pd}: a time-out beats sleep, which beats a watchdog clear
  function automatic logic [1:0] csf_cause(input logic [1:0] to_pd, input logic valid, input logic sleep,
                                           input logic wdt_clear, input logic wdt_timeout);
    logic [1:0] n;
    n = to_pd;
    if (valid && wdt_clear) begin
      n = 2'h3;
    end
    if (valid && sleep) begin
      n = 2'h2;
    end
    // The time-out is a hardware event, so it wins over a clear in the same cycle
    if (wdt_timeout) begin
      n[1] = 1'h0;
    end
    return n;
  endfunction

  // Read decode: unmapped offsets and the upper bytes read as zero
  function automatic logic [31:0] csf_read(input logic [7:0] adr, input logic [7:0] status,
                                           input logic [7:0] result);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (adr)
      `CSF_OFS_STATUS: begin
        d = {24'h00_0000, status};
      end
      `CSF_OFS_RESULT: begin
        d = {24'h00_0000, result};
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction

  assign alu = csf_alu(core_req.op, core_req.opa, core_req.opb, st_ff.status[`CSF_BIT_C]);
  assign bus_req = wb_cyc_i && wb_stb_i && !st_ff.ack;
  assign wstat = wb_sel_i[0] ? wb_dat_i[7:0] : st_ff.status;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = bus_req;
    nxt_st.result_valid = 1'h0;
    if (bus_req && wb_we_i && wb_adr_i == `CSF_OFS_STATUS) begin
      // Software writes behave like a move: no flag logic involved
      nxt_st.status = csf_merge(st_ff.status, wstat, 3'h0, 3'h0);
    end
    if (core_req.valid) begin
      nxt_st.result = alu.res;
      nxt_st.result_valid = 1'h1;
      // A core write in the same cycle overrides a bus write
      if (core_req.dest_status) begin
        nxt_st.status = csf_merge(st_ff.status, alu.res, alu.upd, alu.flags);
      end else begin
        nxt_st.status = csf_apply(nxt_st.status, alu.upd, alu.flags);
      end
    end
    nxt_st.status[`CSF_BIT_TO:`CSF_BIT_PD] = csf_cause(st_ff.status[`CSF_BIT_TO:`CSF_BIT_PD], core_req.valid,
                                                        core_req.sleep, core_req.wdt_clear, core_req.wdt_timeout);
    nxt_st.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      nxt_st.rdata = csf_read(wb_adr_i, st_ff.status, st_ff.result);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '{status: `CSF_STATUS_RST,
                 result: 8'h00,
                 result_valid: 1'h0,
                 ack: 1'h0,
                 rdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.rdata;
  assign wb_ack_o = st_ff.ack;
  assign status_o = st_ff.status;
  assign result_o = st_ff.result;
  assign result_valid_o = st_ff.result_valid;

endmodule // csf_status_reg

// >>> csf_chk.sv
`timescale 1ns/1ns
module csf_chk (
  // Clock and bus
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Core side
  input wire csf_pkg::csf_core_req_t core_req,
  input wire logic [7:0] status_o,
  input wire logic result_valid_o
);
  import csf_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack held");
  property p_due; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_due: assert property (p_due) else $error("no ack");
  property p_rv; core_req.valid |=> result_valid_o; endproperty
  a_rv: assert property (p_rv) else $error("no result");
  property p_tmo; core_req.wdt_timeout |=> !status_o[4]; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout");
  // Low three bits of the request are sleep, watchdog clear, timeout
  property p_slp; core_req.valid && core_req[2:0] == 3'h4 |=> status_o[4:3] == 2'h2; endproperty
  a_slp: assert property (p_slp) else $error("sleep");
  property p_clr; core_req.valid && core_req[2:0] == 3'h2 |=> status_o[4:3] == 2'h3; endproperty
  a_clr: assert property (p_clr) else $error("wdt clear");
  property p_keep; !core_req.valid && !core_req.wdt_timeout |=> $stable(status_o[4:3]); endproperty
  a_keep: assert property (p_keep) else $error("to/pd moved");
  property p_cy; core_req.valid && core_req.op == CSF_OP_ADD && core_req.opa[7] && core_req.opb[7] |=> status_o[0];
  endproperty
  a_cy: assert property (p_cy) else $error("carry");
  property p_clear_file_instruction; core_req.valid && core_req.dest_status && core_req.op == CSF_OP_CLR |=>
    status_o[7:5] == 3'h0 && status_o[2] && status_o[1:0] == $past(status_o[1:0]); endproperty
  a_clear_file_instruction: assert property (p_clear_file_instruction) else $error("clear of status");
  property p_mov; core_req.valid && core_req.op == CSF_OP_MOVE && !core_req.dest_status && !wb_cyc_i |=>
    status_o[2:0] == $past(status_o[2:0]); endproperty
  a_mov: assert property (p_mov) else $error("move touched flags");
endmodule // csf_chk
bind csf_status_reg csf_chk chk_u (.clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .core_req, .status_o,
  .result_valid_o);

// >>> csf_core_model.sv
`timescale 1ns/1ns
module csf_core_model (
  // Core request
  input wire logic clk,
  output csf_pkg::csf_core_req_t core_req
);
  import csf_pkg::*;
  initial core_req = '0;
  // Request lasts one edge, then drops so it is never taken twice
  task automatic issue(input csf_op_t o, input logic [15:0] ab, input logic [3:0] c);
    @(posedge clk);
    core_req <= {1'b1, o, ab, c};
    @(posedge clk);
    core_req <= '0;
    @(negedge clk);
  endtask
endmodule // csf_core_model

// >>> tb.sv
`timescale 1ns/1ns
module tb;
  import csf_pkg::*;
  logic clk = 1'h0, resetn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, rv;
  logic [7:0] adr = 8'h00, st, res;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  csf_core_req_t core_req;
  int n_fail = 0, checks = 0;
  initial forever #4 clk = ~clk;
  csf_core_model core_u (.clk, .core_req);
  csf_status_reg dut_u (.clk, .resetn, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .core_req, .status_o(st),
    .result_o(res), .result_valid_o(rv));
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) n_fail++;
    if (g !== e) $display("wrong value at %0t: got %h", $time, g);
  endtask
  // On a read d is the expected data; it is taken at the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, 4'h1, d};
    @(posedge clk);
    while (ack !== 1'h1) @(posedge clk);
    if (!w) chk(rd, d);
    {cyc, stb} <= 2'h0;
  endtask
  task automatic op(input csf_op_t o, input logic [15:0] ab, input logic [3:0] c, input logic [31:0] e);
    core_u.issue(o, ab, c);
    chk({15'h0, rv, st, res}, e);
  endtask
  task print_verdict;
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task t_alu;
    wb(1'h0, 8'h00, 32'h18);
    wb(1'h0, 8'h40, 32'h0);
    op(CSF_OP_ADD, 16'h8f81, 4'h0, 32'h11b10);
    op(CSF_OP_SUB, 16'h0506, 4'h0, 32'h118ff);
    op(CSF_OP_SUB, 16'h0606, 4'h0, 32'h11f00);
    op(CSF_OP_MOVE, 16'h5500, 4'h0, 32'h11f55);
    op(CSF_OP_RLF, 16'h8100, 4'h0, 32'h11f03);
    op(CSF_OP_RRF, 16'h0200, 4'h0, 32'h11e81);
    wb(1'h0, 8'h04, 32'h81);
    op(CSF_OP_IOR, 16'hf00f, 4'h0, 32'h11aff);
    op(CSF_OP_AND, 16'hf00f, 4'h0, 32'h11e00);
    op(CSF_OP_XOR, 16'h5aa5, 4'h0, 32'h11aff);
    op(CSF_OP_CLR, 16'h0000, 4'h0, 32'h11e00);
  endtask
  task t_wr;
    wb(1'h1, 8'h00, 32'he3);
    wb(1'h0, 8'h00, 32'hfb);
    op(CSF_OP_CLR, 16'h0000, 4'h8, 32'h11f00);
    wb(1'h1, 8'h00, 32'h26);
    wb(1'h0, 8'h00, 32'h3e);
    op(CSF_OP_ADD, 16'h8f81, 4'h8, 32'h11b10);
    op(CSF_OP_RLF, 16'h0000, 4'h8, 32'h11a01);
  endtask
  task t_wdt;
    op(CSF_OP_MOVE, 16'h0000, 4'h1, 32'h10a00);
    op(CSF_OP_MOVE, 16'h0000, 4'h4, 32'h11200);
    op(CSF_OP_MOVE, 16'h0000, 4'h2, 32'h11a00);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    t_alu;
    t_wr;
    t_wdt;
    print_verdict;
  end
  initial begin
    #100000 n_fail++;
    print_verdict;
  end
endmodule // tb
